// *** verif/fc_link_service_responder_bench.sv ***
// Self-checking bench for the link service responder
`default_nettype none
module fc_link_service_responder_bench
  import ls_resp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic send_go = 1'b0;
  logic [3:0] tx_wait = 4'h0;
  logic loop_init = 1'b0;
  logic clk_en = 1'b1;                // Clock enable, lowered by the freeze test
  logic els_done = 1'b0;
  logic abts_reject = 1'b0;
  logic [7:0] abts_reason = 8'h00;
  logic [7:0] abts_expl = 8'h00;
  rx_frame_s send_frame = '0;
  rx_frame_s rx_frame;
  tx_frame_s tx_frame;
  tx_frame_s got_frame;
  logic rx_valid, rx_ready, els_req, abts_req, loop_frame;
  logic tx_valid, tx_ready, got_valid;
  int fails = 0;
  int tests_run = 0;
  int n_got = 0;                      // Answers taken
  int n_lf = 0;                       // Loop-frame pulses seen
  always #2.5 clk_sys = ~clk_sys;
  // Upper layer completes a pending request one cycle later
  always @(posedge clk_sys) els_done <= (els_req === 1'b1) && !els_done;
  always @(posedge clk_sys) if (got_valid === 1'b1) n_got <= n_got + 1;
  always @(posedge clk_sys) if (loop_frame === 1'b1) n_lf <= n_lf + 1;
  fc_link_service_responder dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready), .loop_init(loop_init),
    .els_done(els_done), .abts_reject(abts_reject), .abts_reason(abts_reason),
    .abts_expl(abts_expl), .els_req(els_req), .abts_req(abts_req), .loop_frame(loop_frame),
    .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready));
  fc_peer_model peer_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .send_go(send_go),
    .send_frame(send_frame), .tx_wait(tx_wait), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
    .got_valid(got_valid), .got_frame(got_frame));
  // ====
  task automatic chk(input string what, input logic [203:0] exp, input logic [203:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // Request frame; parameter word is junk with its validity bit clear
  function automatic rx_frame_s mk(input logic [7:0] ft, input logic [7:0] rc,
                                   input logic [15:0] pl, input logic [15:0] ox);
    return '{r_ctl: rc, d_id: 24'h0A0B0C, s_id: 24'h112233, ftype: ft, f_ctl: 24'h0,
             seq_id: 8'h3C, seq_cnt: 16'h7, ox_id: ox, rx_id: 16'h5A5A,
             param: 32'hDEADBEEF, pl_b0: pl[15:8], pl_b1: pl[7:0]};
  endfunction : mk
  // Offer one frame, collect any answer, check header and payload
  task automatic run(input rx_frame_s f, input rsp_kind_e k, input logic [95:0] pl);
    int n0;
    int i;
    logic bls;
    logic [7:0] rc;
    n0 = n_got;
    bls = (k == RSP_BA_ACC) || (k == RSP_BA_RJT);
    rc = !bls ? 8'h23 : (k == RSP_BA_ACC) ? 8'h84 : 8'h85;
    send_frame <= f;
    send_go <= 1'b1;
    @(posedge clk_sys);
    send_go <= 1'b0;
    for (i = 0; i < 40 && got_valid !== 1'b1; i++) @(negedge clk_sys);
    repeat (10) @(posedge clk_sys);
    chk("answers", 204'(k != RSP_NONE), 204'(n_got - n0));
    if (k != RSP_NONE) begin
      chk("header", 204'({k, rc, bls ? 8'h00 : 8'h01, f.s_id, f.d_id, f.ox_id, f.rx_id}),
          204'({got_frame.kind, got_frame.r_ctl, got_frame.ftype, got_frame.d_id,
           got_frame.s_id, got_frame.ox_id, got_frame.rx_id}));
      chk("payload", 204'(pl), 204'(got_frame.payload));
    end
  endtask : run
  // ====
  task automatic t_abts;
    tx_wait <= 4'h3;
    for (int i = 0; i < 2; i++) begin
      run(mk(8'h00, 8'h81, 16'hA55A, 16'h1200 + 16'(i)), RSP_BA_ACC,
          {16'h0000, 16'h0000, 16'h1200 + 16'(i), 16'h5A5A, 32'h0});
    end
    tx_wait <= 4'h0;
    $display("test abts accept done");
  endtask : t_abts
  task automatic t_abts_rej;
    logic [7:0] rsn [6] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'hFF};
    logic [7:0] exl [3] = '{8'h00, 8'h03, 8'h05};
    for (int i = 0; i < 6; i++) begin
      abts_reject <= 1'b1;
      abts_reason <= rsn[i];
      abts_expl <= exl[i % 3];
      run(mk(8'h00, 8'h81, 16'h0, 16'h3300 + 16'(i)), RSP_BA_RJT,
          {8'h00, rsn[i], exl[i % 3], 8'h00, 64'h0});
    end
    abts_reject <= 1'b0;
    $display("test abts reject done");
  endtask : t_abts_rej
  task automatic t_silent;
    logic [15:0] tbl [8] = '{16'h0080, 16'h0082, 16'h0084, 16'h0085,
                             16'h0083, 16'h008F, 16'h0123, 16'h0822};
    for (int i = 0; i < 8; i++) begin
      run(mk(tbl[i][15:8], tbl[i][7:0], 16'h0300, 16'h4400), RSP_NONE, 96'h0);
    end
    $display("test silent drop done");
  endtask : t_silent
  task automatic t_els;
    logic [7:0] cd [14] = '{8'h52, 8'h60, 8'h04, 8'h05, 8'h50, 8'h03, 8'h20,
                            8'h21, 8'h0F, 8'h53, 8'h78, 8'h12, 8'h24, 8'h7D};
    for (int i = 0; i < 14; i++) begin
      run(mk(8'h01, 8'h22, {cd[i], 8'h00}, 16'h5500 + 16'(i)), RSP_LS_ACC,
          {8'h02, 88'h0});
    end
    $display("test supported requests done");
  endtask : t_els
  task automatic t_rjt;
    logic [15:0] cd [13] = '{16'h1100, 16'h1108, 16'h7E00, 16'h0000, 16'hFF00, 16'h0100,
      16'h1101, 16'h1102, 16'h1103, 16'h1104, 16'h1105, 16'h1106, 16'h1107};
    for (int i = 0; i < 13; i++) begin
      run(mk(8'h01, 8'h22, cd[i], 16'h6600 + 16'(i)), RSP_LS_RJT,
          {32'h01000000, 8'h00, 8'h0B, 8'h00, 8'h00, 32'h0});
    end
    $display("test reject done");
  endtask : t_rjt
  task automatic t_loop;
    int n0;
    loop_init <= 1'b1;
    for (int q = 1; q < 8; q++) begin
      n0 = n_lf;
      run(mk(8'h01, 8'h22, {8'h11, 8'(q)}, 16'h7700), RSP_NONE, 96'h0);
      chk("loop pulse", 204'd1, 204'(n_lf - n0));
    end
    loop_init <= 1'b0;
    $display("test loop init done");
  endtask : t_loop
  // Clock enable low holds a pending ABTS; a reset then clears it
  task automatic t_freeze;
    send_frame <= mk(8'h00, 8'h81, 16'h0, 16'h8800);
    send_go <= 1'b1;
    @(posedge clk_sys);
    send_go <= 1'b0;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("frozen abts", 204'h2, 204'({abts_req, tx_valid}));
    chk("frozen ready", 204'h0, 204'(rx_ready));
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    clk_en <= 1'b1;
    @(negedge clk_sys);
    chk("reset idle", 204'h1,
        204'({abts_req, tx_valid, els_req, loop_frame, rx_ready}));
    @(posedge clk_sys);
    run(mk(8'h01, 8'h22, 16'h7E00, 16'h8801), RSP_LS_RJT,
        {32'h01000000, 8'h00, 8'h0B, 8'h00, 8'h00, 32'h0});
    $display("test freeze and reset done");
  endtask : t_freeze
  // ====
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_abts();
    t_abts_rej();
    t_silent();
    t_els();
    t_rjt();
    t_loop();
    t_freeze();
    report_and_stop();
  end
  // Hang guard, far beyond the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end
endmodule : fc_link_service_responder_bench
`default_nettype wire

// *** verif/fc_peer_model.sv ***
// Far-side port model: offers request frames, takes answer frames
`default_nettype none
module fc_peer_model
  import ls_resp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       send_go,    // Start offering send_frame
  input  wire rx_frame_s  send_frame,
  input  wire logic [3:0] tx_wait,    // Stall cycles before taking an answer
  output logic            rx_valid,
  output rx_frame_s       rx_frame,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire tx_frame_s  tx_frame,
  output logic            tx_ready,
  output logic            got_valid,  // One pulse per answer taken
  output tx_frame_s       got_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  logic [3:0] wait_q;                 // Stall counter
  // Request held until taken; idle bus toggles so stale data never looks valid
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_valid <= 1'b0;
      rx_frame <= '1;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      rx_frame <= ~rx_frame;
    end else if (send_go) begin
      rx_valid <= 1'b1;
      rx_frame <= send_frame;
    end else if (!rx_valid) begin
      rx_frame <= ~rx_frame;
    end
  end
  // Answer side: prompt or slow, one answer per handshake
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_ready  <= 1'b0;
      wait_q    <= 4'h0;
      got_valid <= 1'b0;
      got_frame <= '0;
    end else if (tx_valid && tx_ready) begin
      tx_ready  <= 1'b0;
      wait_q    <= 4'h0;
      got_valid <= 1'b1;
      got_frame <= tx_frame;
    end else begin
      got_valid <= 1'b0;
      if (tx_valid && wait_q >= tx_wait) begin
        tx_ready <= 1'b1;
      end else if (tx_valid) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : fc_peer_model
`default_nettype wire

// *** verilog/fc_link_service_responder.sv ***
// Link service frame classifier and responder
// Summary of operation
// RULE1: BLS is TYPE 00h, R_CTL 1000xxxxb
// RULE2: Decode NOP, ABTS, RMC, BA_ACC, BA_RJT codes
// RULE3: NOP and RMC dropped without reply
// RULE4: Reserved and invalid fields never checked
// RULE5: Each ABTS gets exactly one answer
// RULE6: BA_ACC only ever answers ABTS
// RULE7: BA_ACC payload is twelve fixed bytes
// RULE8: SEQ_ID validity and SEQ_ID both 00h
// RULE9: BA_ACC carries aborted exchange identifiers
// RULE10: Both SEQ_CNT fields set to 0000h
// RULE11: BA_RJT payload is four bytes
// RULE12: BA_RJT reason codes as listed
// RULE13: BA_RJT explanations as listed
// RULE14: ELS is TYPE 01h, R_CTL 22h/23h
// RULE15: First payload byte: command, 02h/01h replies
// RULE16: Fourteen supported ELS request codes
// RULE17: Code 11h second byte selects loop frame
// RULE18: Loop frame outside init gets LS_RJT
// RULE19: Unsupported ELS gets LS_RJT 0Bh/00h
// RULE20: Supported request completion gets LS_ACC
// RULE21: Sequence frames share direction and SEQ_ID
// RULE22: Exchange frames carry OX_ID and RX_ID
// RULE23: LS_RJT reason byte 5, explanation byte 6
// RULE24: Reply swaps IDs, keeps exchange IDs
`default_nettype none
module fc_link_service_responder
  import ls_resp_pkg::*;
(
  input  wire logic      clk_sys,      // Core clock, 200 MHz
  input  wire logic      sys_rst,      // Synchronous reset, active high
  input  wire logic      clk_en,       // Freezes all state while low
  input  wire logic      rx_valid,     // Received frame offered
  input  wire rx_frame_s rx_frame,     // Received frame header and payload head
  output logic           rx_ready,     // Frame taken this cycle
  input  wire logic      loop_init,    // Port is running loop initialization
  input  wire logic      els_done,     // Upper layer finished a supported request
  input  wire logic      abts_reject,  // Upper layer refuses the pending ABTS
  input  wire logic [7:0] abts_reason, // Reason code for that refusal
  input  wire logic [7:0] abts_expl,   // Explanation for that refusal
  output logic           els_req,      // Supported ELS request awaiting completion
  output logic           abts_req,     // ABTS awaiting accept or reject decision
  output logic           loop_frame,   // Loop-init frame seen during loop init, pulse
  output logic           tx_valid,     // Answer frame offered
  output tx_frame_s      tx_frame,     // Answer frame contents
  input  wire logic      tx_ready      // Transmitter takes answer
);

  // ==========================================================
  // Decode helpers
  // Supported extended request code check
  function automatic logic els_supported(input logic [7:0] code);
    case (code)
      8'h52, 8'h60, 8'h04, 8'h05, 8'h50, 8'h03, 8'h20,
      8'h21, 8'h0F, 8'h53, 8'h78, 8'h12, 8'h24, 8'h7D: els_supported = 1'b1; // [RULE16]
      default: els_supported = 1'b0;
    endcase
  endfunction : els_supported

  // Loop-init qualifier range check on the second payload byte
  function automatic logic is_loop_qual(input logic [7:0] q);
    is_loop_qual = (q >= LI_FIRST) && (q <= LI_LAST); // [RULE17]
  endfunction : is_loop_qual

  // ==========================================================
  // State machine
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,  // Waiting for a frame
    ST_ABTS = 4'b0010,  // ABTS held for decision
    ST_ELS  = 4'b0100,  // Supported request in progress
    ST_SEND = 4'b1000   // Answer waiting for transmitter
  } state_e;

  state_e    state_q, state_d;   // Control state
  rx_frame_s req_q, req_d;       // Captured request
  tx_frame_s tx_q, tx_d;         // Answer being offered
  logic      lf_q, lf_d;         // Loop-init pulse register

  // Classification of the offered frame; only TYPE, R_CTL and payload
  // bytes are looked at, never reserved or parameter fields [RULE4]
  // Kind flags of the offered frame
  logic is_bls, is_els_req;
  logic [3:0] bls_code;
  always_comb begin
    is_bls     = (rx_frame.ftype == TYPE_BLS) && (rx_frame.r_ctl[7:4] == RCTL_BLS_HI); // [RULE1]
    bls_code   = rx_frame.r_ctl[3:0];                                                 // [RULE1]
    is_els_req = (rx_frame.ftype == TYPE_ELS) && (rx_frame.r_ctl == RCTL_ELS_REQ);   // [RULE14]
  end

  // Frame accepted only when idle, so one answer per request
  assign rx_ready = (state_q == ST_IDLE) && clk_en;

  // Build an answer header: IDs swapped, exchange kept [RULE24] [RULE22]
  // An answer is a one-frame sequence flowing back to the requester [RULE21]
  function automatic tx_frame_s reply_hdr(input rx_frame_s r, input rsp_kind_e k);
    tx_frame_s t;
    t = '0;
    t.kind  = k;
    t.d_id  = r.s_id;
    t.s_id  = r.d_id;
    t.ox_id = r.ox_id;
    t.rx_id = r.rx_id;
    reply_hdr = t;
  endfunction : reply_hdr

  // Next-state logic
  always_comb begin
    state_d = state_q;
    req_d   = req_q;
    tx_d    = tx_q;
    lf_d    = 1'b0;
    // One request in flight; intake reopens only when idle
    case (state_q)
      ST_IDLE: begin
        if (rx_valid) begin
          req_d = rx_frame;
          if (is_bls) begin
            case (bls_code)                                              // [RULE2]
              BLS_ABTS: state_d = ST_ABTS;                               // [RULE5]
              // NOP, RMC and replies are dropped, no answer frame
              BLS_NOP, BLS_RMC, BLS_BA_ACC, BLS_BA_RJT: state_d = ST_IDLE; // [RULE3]
              default: state_d = ST_IDLE;
            endcase
          end else if (is_els_req) begin
            if (rx_frame.pl_b0 == ELS_LOOP_INIT && is_loop_qual(rx_frame.pl_b1)
                && loop_init) begin
              // Loop init engine consumes it; no link service answer
              lf_d = 1'b1;                                               // [RULE17]
            end else if (els_supported(rx_frame.pl_b0)) begin
              state_d = ST_ELS;
            end else begin
              // Unsupported, TEST, or loop frame out of context
              tx_d = reply_hdr(rx_frame, RSP_LS_RJT);
              tx_d.r_ctl    = RCTL_ELS_RPL;                              // [RULE14]
              tx_d.ftype    = TYPE_ELS;
              tx_d.els_code = ELS_LS_RJT;                                // [RULE15]
              // Payload bytes 0..11, byte 0 in the top lane
              tx_d.payload  = {ELS_LS_RJT, 24'h000000, 8'h00, LRJ_NOT_SUPP,
                               LEX_NONE, 8'h00, 32'h00000000};           // [RULE23] [RULE19] [RULE18]
              state_d = ST_SEND;
            end
          end
          // Anything else is not a link service request and is left alone
        end
      end
      // Decision made in the first enabled cycle, accept by default
      ST_ABTS: begin
        if (abts_reject) begin
          tx_d = reply_hdr(req_q, RSP_BA_RJT);
          tx_d.r_ctl   = {RCTL_BLS_HI, BLS_BA_RJT};
          tx_d.ftype   = TYPE_BLS;
          tx_d.payload = {8'h00, abts_reason, abts_expl, 8'h00, 64'h0}; // [RULE11] [RULE12] [RULE13]
          state_d = ST_SEND;                                             // [RULE5]
        end else begin
          // Accept by default: whole exchange is aborted
          tx_d = reply_hdr(req_q, RSP_BA_ACC);                           // [RULE6]
          tx_d.r_ctl   = {RCTL_BLS_HI, BLS_BA_ACC};
          tx_d.ftype   = TYPE_BLS;
          tx_d.payload = {SEQID_INVALID, SEQID_ZERO, 16'h0000,           // [RULE8]
                          req_q.ox_id, req_q.rx_id,                      // [RULE9] [RULE7]
                          SEQCNT_ZERO, SEQCNT_ZERO};                     // [RULE10]
          state_d = ST_SEND;
        end
      end
      // Upper layer owns the request until it reports completion
      ST_ELS: begin
        if (els_done) begin
          tx_d = reply_hdr(req_q, RSP_LS_ACC);                           // [RULE20]
          tx_d.r_ctl    = RCTL_ELS_RPL;
          tx_d.ftype    = TYPE_ELS;
          tx_d.els_code = ELS_LS_ACC;                                    // [RULE15]
          tx_d.payload  = {ELS_LS_ACC, 88'h0};
          state_d = ST_SEND;
        end
      end
      // Answer stands until the transmitter takes it
      ST_SEND: begin
        if (tx_ready) begin
          state_d = ST_IDLE;
          tx_d.kind = RSP_NONE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      req_q   <= '0;
      tx_q    <= '0;
      lf_q    <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      req_q   <= req_d;
      tx_q    <= tx_d;
      lf_q    <= lf_d;
    end
  end

  // Outputs
  assign tx_valid   = (state_q == ST_SEND);
  assign tx_frame   = tx_q;
  assign abts_req   = (state_q == ST_ABTS);
  assign els_req    = (state_q == ST_ELS);
  assign loop_frame = lf_q;

  // ==========================================================
  // Assertions
  // ABTS taken from the far side
  sequence s_abts_in;
    rx_valid && rx_ready && is_bls && bls_code == BLS_ABTS;
  endsequence
  // Basic answer on offer
  sequence s_answer_ba;
    tx_valid && (tx_q.kind == RSP_BA_ACC || tx_q.kind == RSP_BA_RJT);
  endsequence
  // Loop-init frame taken while the port runs loop initialization
  sequence s_loop_in;
    rx_valid && rx_ready && is_els_req && rx_frame.pl_b0 == ELS_LOOP_INIT
      && is_loop_qual(rx_frame.pl_b1) && loop_init;
  endsequence
  // Supported extended request taken
  sequence s_supp_in;
    rx_valid && rx_ready && is_els_req && els_supported(rx_frame.pl_b0);
  endsequence

  // Answer follows the first enabled decision cycle; a frozen one just waits
  a_abts_one_answer: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE5]
    s_abts_in ##1 clk_en |=> s_answer_ba)
    else $error("ABTS not answered");
  // A rising basic accept must come straight from the ABTS state
  a_ba_acc_only_abts: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE6]
    $rose(tx_valid) && tx_q.kind == RSP_BA_ACC |-> $past(state_q) == ST_ABTS)
    else $error("BA_ACC without ABTS");
  // Validity, sequence and both count fields stay zero
  a_ba_acc_fields: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE8]
    tx_valid && tx_q.kind == RSP_BA_ACC |-> tx_q.payload[95:80] == 16'h0000
      && tx_q.payload[31:0] == 32'h0)
    else $error("BA_ACC fixed fields wrong");
  // Accept names the exchange that was aborted
  a_ba_acc_xid: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE9]
    tx_valid && tx_q.kind == RSP_BA_ACC |-> tx_q.payload[63:48] == req_q.ox_id
      && tx_q.payload[47:32] == req_q.rx_id)
    else $error("BA_ACC exchange IDs wrong");
  // NOP and RMC codes leave the block idle
  a_nop_silent: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE3]
    rx_valid && rx_ready && is_bls && (bls_code == BLS_NOP || bls_code == BLS_RMC)
      |=> state_q == ST_IDLE)
    else $error("NOP or RMC produced activity");
  // Unknown requests rejected as not supported
  a_unsupp_rjt: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE19]
    rx_valid && rx_ready && is_els_req && !els_supported(rx_frame.pl_b0)
      && rx_frame.pl_b0 != ELS_LOOP_INIT
      |=> tx_valid && tx_q.kind == RSP_LS_RJT && tx_q.payload[55:48] == LRJ_NOT_SUPP)
    else $error("Unsupported ELS not rejected");
  // Loop frame outside initialization rejected
  a_loop_out_ctx: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE18]
    rx_valid && rx_ready && is_els_req && rx_frame.pl_b0 == ELS_LOOP_INIT && !loop_init
      |=> tx_valid && tx_q.kind == RSP_LS_RJT && tx_q.payload[47:40] == LEX_NONE)
    else $error("Loop frame outside init not rejected");
  // Completion turns into an accept next cycle
  a_ls_acc_done: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE20]
    els_req && els_done && clk_en |=> tx_valid && tx_q.kind == RSP_LS_ACC)
    else $error("LS_ACC missing after completion");
  // Reply addressed back to the requester
  a_reply_swap: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE24]
    tx_valid |-> tx_q.d_id == req_q.s_id && tx_q.s_id == req_q.d_id
      && tx_q.ox_id == req_q.ox_id)
    else $error("Reply identifiers not swapped");

  // ABTS decoded into the pending-decision state
  a_bls_decode: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE2]
    s_abts_in |=> abts_req)
    else $error("ABTS not decoded");
  // Answer withdrawn right after an enabled handshake; a handshake while frozen leaves it on offer
  a_answer_once: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE5]
    tx_valid && tx_ready && clk_en |=> !tx_valid)
    else $error("Answer offered twice");
  // Reserved and vendor bytes of a basic reject are zero
  a_ba_rjt_fields: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE11]
    tx_valid && tx_q.kind == RSP_BA_RJT |-> tx_q.payload[95:88] == 8'h00
      && tx_q.payload[71:0] == 72'h0)
    else $error("BA_RJT fixed bytes wrong");
  // Reject code leads both the command field and the payload
  a_ls_rjt_code: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE15]
    tx_valid && tx_q.kind == RSP_LS_RJT |-> tx_q.els_code == ELS_LS_RJT
      && tx_q.payload[95:88] == ELS_LS_RJT)
    else $error("LS_RJT code wrong");
  // Loop-init frame during initialization: pulse, no answer
  a_loop_consumed: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE17]
    s_loop_in |=> loop_frame && !tx_valid)
    else $error("Loop frame not consumed");
  // Supported request waits for the upper layer
  a_supp_pending: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE16]
    s_supp_in |=> els_req && !tx_valid)
    else $error("Supported ELS not pending");
  // Low clock enable freezes every register; reset edges are left out
  a_freeze_state: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clk_en && !sys_rst |=> $stable(state_q) && $stable(tx_q) && $stable(req_q)
      && $stable(loop_frame))
    else $error("State moved while frozen");
  // Reset leaves every output idle at the next edge
  a_reset_quiet: assert property (@(posedge clk_sys)
    sys_rst |=> !tx_valid && !abts_req && !els_req && !loop_frame)
    else $error("Outputs busy after reset");

endmodule : fc_link_service_responder
`default_nettype wire

// *** verilog/ls_resp_pkg.sv ***
// Constants and carrier types for the link service responder
`default_nettype none
package ls_resp_pkg;
  // ==========================================================
  // Header field codes
  localparam logic [7:0] TYPE_BLS      = 8'h00;
  localparam logic [7:0] TYPE_ELS      = 8'h01;
  localparam logic [3:0] RCTL_BLS_HI   = 4'h8;
  localparam logic [7:0] RCTL_ELS_REQ  = 8'h22;
  localparam logic [7:0] RCTL_ELS_RPL  = 8'h23;
  // Basic link service command codes
  localparam logic [3:0] BLS_NOP       = 4'h0;
  localparam logic [3:0] BLS_ABTS      = 4'h1;
  localparam logic [3:0] BLS_RMC       = 4'h2;
  localparam logic [3:0] BLS_BA_ACC    = 4'h4;
  localparam logic [3:0] BLS_BA_RJT    = 4'h5;
  // BA_ACC field values
  localparam logic [7:0] SEQID_INVALID = 8'h00;
  localparam logic [7:0] SEQID_VALID   = 8'h80;
  localparam logic [7:0] SEQID_ZERO    = 8'h00;
  localparam logic [15:0] SEQCNT_ZERO  = 16'h0000;
  // BA_RJT reason codes and explanations
  localparam logic [7:0] BRJ_INVALID_CMD = 8'h01;
  localparam logic [7:0] BRJ_LOGICAL_ERR = 8'h03;
  localparam logic [7:0] BRJ_LOGICAL_BSY = 8'h05;
  localparam logic [7:0] BRJ_PROTO_ERR   = 8'h07;
  localparam logic [7:0] BRJ_UNABLE      = 8'h09;
  localparam logic [7:0] BRJ_VENDOR      = 8'hFF;
  localparam logic [7:0] BEX_NONE        = 8'h00;
  localparam logic [7:0] BEX_BAD_XID     = 8'h03;
  localparam logic [7:0] BEX_SEQ_ABORTED = 8'h05;
  // Extended link service codes
  localparam logic [7:0] ELS_LS_ACC    = 8'h02;
  localparam logic [7:0] ELS_LS_RJT    = 8'h01;
  localparam logic [7:0] ELS_LOOP_INIT = 8'h11;
  localparam logic [7:0] LI_FIRST      = 8'h01;
  localparam logic [7:0] LI_LAST       = 8'h07;
  localparam logic [7:0] LRJ_NOT_SUPP  = 8'h0B;
  localparam logic [7:0] LEX_NONE      = 8'h00;
  // Parameter-field validity bit in F_CTL
  localparam int         FCTL_PARAM_BIT = 3;

  // Received frame summary
  typedef struct packed {
    logic [7:0]  r_ctl;
    logic [23:0] d_id;
    logic [23:0] s_id;
    logic [7:0]  ftype;
    logic [23:0] f_ctl;
    logic [7:0]  seq_id;
    logic [15:0] seq_cnt;
    logic [15:0] ox_id;
    logic [15:0] rx_id;
    logic [31:0] param;
    logic [7:0]  pl_b0;
    logic [7:0]  pl_b1;
  } rx_frame_s;

  // Kind of answer produced
  typedef enum logic [3:0] {
    RSP_NONE   = 4'h0,
    RSP_BA_ACC = 4'h1,
    RSP_BA_RJT = 4'h2,
    RSP_LS_ACC = 4'h3,
    RSP_LS_RJT = 4'h4
  } rsp_kind_e;

  // Outgoing answer header and payload head
  typedef struct packed {
    rsp_kind_e   kind;
    logic [7:0]  r_ctl;
    logic [7:0]  ftype;
    logic [23:0] d_id;
    logic [23:0] s_id;
    logic [15:0] ox_id;
    logic [15:0] rx_id;
    logic [7:0]  els_code;
    logic [95:0] payload;
  } tx_frame_s;
endpackage : ls_resp_pkg
`default_nettype wire
